// ==== rtl/rtctk_pkg.sv ====
// Purpose: constants for the rtc timekeeping counters
// Assumes: 8-bit sfr bus of the on-chip core, 100 MHz mclk
// Notes:   offsets are sfr addresses
package rtctk_pkg;
   // ----------------------------------------------------------------
   // register offsets
   // ----------------------------------------------------------------
   localparam logic [7:0] CONFIG_ADDR   = 8'hA1;
   localparam logic [7:0] FRAC_ADDR     = 8'hA2;
   localparam logic [7:0] SEC_ADDR      = 8'hA3;
   localparam logic [7:0] MIN_ADDR      = 8'hA4;
   localparam logic [7:0] HOUR_ADDR     = 8'hA5;
   localparam logic [7:0] ALARM_INTERVAL_TARGET_ADDR   = 8'hA6;
   localparam logic [7:0] KEY_ADDR      = 8'hC1;
   localparam logic [7:0] NOMTRIM_ADDR  = 8'hF6;
   localparam logic [7:0] THERMTRIM_ADDR = 8'hF7;
   // ----------------------------------------------------------------
   // config register fields
   // ----------------------------------------------------------------
   localparam int TFH_BIT      = 6;
   localparam int DAYFLAG_BIT  = 5;
   localparam int ITS_LSB      = 4;
   localparam int SIT_BIT      = 3;
   localparam int ALARM_BIT    = 2;
   localparam int INTERVAL_TIMER_ON_BIT     = 1;
   localparam logic [7:0] CONFIG_RESET = 8'h01;
   localparam logic [7:0] COUNT_RESET  = 8'h00;
   localparam logic [7:0] TRIM_RESET   = 8'h00;
   // ----------------------------------------------------------------
   // counter limits and key
   // ----------------------------------------------------------------
   localparam logic [7:0] FRAC_LAST  = 8'h7F;
   localparam logic [7:0] SEC_LAST   = 8'h3B;
   localparam logic [7:0] MIN_LAST   = 8'h3B;
   localparam logic [7:0] HOUR24_LAST = 8'h17;
   localparam logic [7:0] HOUR256_LAST = 8'hFF;
   localparam logic [7:0] TIME_KEY   = 8'hEA;
   localparam int XTAL_DIV           = 256;
   typedef enum logic [1:0] {
      rtctk_base_frac, rtctk_base_sec, rtctk_base_min, rtctk_base_hour
   } rtctk_base_t;
endpackage

// ==== rtl/rtctk_tick_div.sv ====
// Purpose: divides the compensated 32.768 kHz tick stream into 128 Hz ticks
// Assumes: xtal_tick is a one-cycle pulse per crystal period
// Notes:   divide ratio is a parameter
`timescale 1ns/1ps
module rtctk_tick_div #(
   parameter int DIV = rtctk_pkg::XTAL_DIV
) (
   input  wire logic mclk,       // system clock
   input  wire logic arst_n,     // power-on reset, low
   input  wire logic xtal_tick,  // crystal tick pulse
   output logic      frac_tick   // 128 Hz tick pulse
);
   initial begin
      if (DIV < 2 || DIV > 65536) $error("rtctk_tick_div: bad DIV");
   end
   typedef struct packed {
      logic [15:0] cnt;
      logic        tick;
   } rtctk_div_t;
   rtctk_div_t st_reg, st_next;
   always_comb begin
      st_next = st_reg;
      st_next.tick = 1'b0;
      if (xtal_tick) begin
         if (st_reg.cnt == 16'(DIV - 1)) begin
            st_next.cnt  = 16'h0000;
            st_next.tick = 1'b1;
         end else begin
            st_next.cnt = st_reg.cnt + 16'h0001;
         end
      end
   end
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end
   assign frac_tick = st_reg.tick;
endmodule

// ==== rtl/rtctk_core.sv ====
// Purpose: rtc timekeeping counters, interval alarm and trim registers
// Assumes: sfr accesses synchronous to mclk; arst_n is power-on reset only
// Notes:   trim values are exported to the crystal compensation logic
`timescale 1ns/1ps
module rtctk_core #(
   parameter int XTAL_DIV = rtctk_pkg::XTAL_DIV
) (
   input  wire logic       mclk,           // 100 MHz clock
   input  wire logic       arst_n,         // power-on reset, low
   input  wire logic       xtal_tick,      // compensated crystal tick
   input  wire logic [7:0] sfr_addr,       // sfr address
   input  wire logic       sfr_wr,         // sfr write strobe
   input  wire logic [7:0] sfr_wdata,      // sfr write data
   output logic      [7:0] sfr_rdata,      // sfr read data, combinational
   output logic            rtc_irq_pend,   // pending clock interrupt pulse
   output logic      [7:0] nom_trim,       // nominal trim to compensator
   output logic      [7:0] therm_trim      // thermal trim to compensator
);
   typedef struct packed {
      logic [7:0] frac;
      logic [7:0] sec;
      logic [7:0] min;
      logic [7:0] hour;
      logic [7:0] target;
      logic [7:0] ivcnt;
      logic [7:0] key;
      logic [7:0] cfg;
      logic [7:0] nom;
      logic [7:0] therm;
      logic       ivdone;
      logic       irq;
   } rtctk_state_t;

   rtctk_state_t st_reg, st_next;
   logic         frac_tick;

   // ----------------------------------------------------------------
   // tick divider
   // ----------------------------------------------------------------
   rtctk_tick_div #(.DIV(XTAL_DIV)) u_div (
      .mclk      (mclk),
      .arst_n    (arst_n),
      .xtal_tick (xtal_tick),
      .frac_tick (frac_tick)
   );

   function automatic logic sel(input logic [7:0] a, input logic [7:0] b);
      sel = sfr_wr && (a == b);
   endfunction

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb begin
      logic        w_frac, w_sec, w_min, w_hour;
      logic        unlocked;
      logic        c_sec, c_min, c_hour, c_day;
      logic [7:0]  hour_last;
      logic        base_tick;
      logic        alarm_set, day_set;
      w_frac    = 1'b0;
      w_sec     = 1'b0;
      w_min     = 1'b0;
      w_hour    = 1'b0;
      unlocked  = 1'b0;
      c_sec     = 1'b0;
      c_min     = 1'b0;
      c_hour    = 1'b0;
      c_day     = 1'b0;
      hour_last = 8'h00;
      base_tick = 1'b0;
      alarm_set = 1'b0;
      day_set   = 1'b0;
      st_next     = st_reg;
      st_next.irq = 1'b0;

      unlocked = (st_reg.key == rtctk_pkg::TIME_KEY);
      w_frac   = unlocked && sel(sfr_addr, rtctk_pkg::FRAC_ADDR);
      w_sec    = unlocked && sel(sfr_addr, rtctk_pkg::SEC_ADDR);
      w_min    = unlocked && sel(sfr_addr, rtctk_pkg::MIN_ADDR);
      w_hour   = unlocked && sel(sfr_addr, rtctk_pkg::HOUR_ADDR);

      hour_last = st_reg.cfg[rtctk_pkg::TFH_BIT] ? rtctk_pkg::HOUR24_LAST
                                                 : rtctk_pkg::HOUR256_LAST;

      // time chain
      if (frac_tick) begin
         c_sec = (st_reg.frac == rtctk_pkg::FRAC_LAST);
         st_next.frac = c_sec ? 8'h00 : st_reg.frac + 8'h01;
      end
      if (c_sec) begin
         c_min = (st_reg.sec == rtctk_pkg::SEC_LAST);
         st_next.sec = c_min ? 8'h00 : st_reg.sec + 8'h01;
      end
      if (c_min) begin
         c_hour = (st_reg.min == rtctk_pkg::MIN_LAST);
         st_next.min = c_hour ? 8'h00 : st_reg.min + 8'h01;
      end
      if (c_hour) begin
         c_day = (st_reg.hour == hour_last);
         st_next.hour = c_day ? 8'h00 : st_reg.hour + 8'h01;
      end
      day_set = c_day;

      // software writes override the same-cycle count
      if (w_frac) begin
         st_next.frac = sfr_wdata;
      end
      if (w_sec) begin
         st_next.sec = sfr_wdata;
      end
      if (w_min) begin
         st_next.min = sfr_wdata;
      end
      if (w_hour) begin
         st_next.hour = sfr_wdata;
      end

      // interval timer
      unique case (rtctk_pkg::rtctk_base_t'(st_reg.cfg[rtctk_pkg::ITS_LSB -: 2]))
         rtctk_pkg::rtctk_base_frac: base_tick = frac_tick;
         rtctk_pkg::rtctk_base_sec:  base_tick = c_sec;
         rtctk_pkg::rtctk_base_min:  base_tick = c_min;
         rtctk_pkg::rtctk_base_hour: base_tick = c_hour;
      endcase
      if (!st_reg.cfg[rtctk_pkg::INTERVAL_TIMER_ON_BIT]) begin
         st_next.ivcnt  = 8'h00;
         st_next.ivdone = 1'b0;
      end else if (base_tick && !st_reg.ivdone) begin
         if (st_reg.ivcnt + 8'h01 == st_reg.target) begin
            alarm_set     = 1'b1;
            st_next.ivcnt = 8'h00;
            st_next.ivdone = st_reg.cfg[rtctk_pkg::SIT_BIT];
         end else begin
            st_next.ivcnt = st_reg.ivcnt + 8'h01;
         end
      end

      // register writes
      if (sel(sfr_addr, rtctk_pkg::CONFIG_ADDR)) begin
         // flags clear by writing zero; they cannot be set by software
         st_next.cfg = {1'b0, sfr_wdata[6], sfr_wdata[5] & st_reg.cfg[5],
                        sfr_wdata[4:3], sfr_wdata[2] & st_reg.cfg[2], sfr_wdata[1:0]};
      end
      if (sel(sfr_addr, rtctk_pkg::ALARM_INTERVAL_TARGET_ADDR)) begin
         st_next.target = sfr_wdata;
      end
      if (sel(sfr_addr, rtctk_pkg::KEY_ADDR)) begin
         st_next.key = sfr_wdata;
      end
      if (sel(sfr_addr, rtctk_pkg::NOMTRIM_ADDR)) begin
         st_next.nom = sfr_wdata;
      end
      if (sel(sfr_addr, rtctk_pkg::THERMTRIM_ADDR)) begin
         st_next.therm = sfr_wdata;
      end

      // hardware set wins over a same-cycle clear
      if (day_set) begin
         st_next.cfg[rtctk_pkg::DAYFLAG_BIT] = 1'b1;
      end
      if (alarm_set) begin
         st_next.cfg[rtctk_pkg::ALARM_BIT] = 1'b1;
      end
      st_next.irq = day_set || alarm_set;
   end

   // ----------------------------------------------------------------
   // state register, power-on reset only
   // ----------------------------------------------------------------
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         st_reg        <= '0;
         st_reg.cfg    <= rtctk_pkg::CONFIG_RESET;
         st_reg.nom    <= rtctk_pkg::TRIM_RESET;
         st_reg.therm  <= rtctk_pkg::TRIM_RESET;
         st_reg.target <= rtctk_pkg::COUNT_RESET;
      end else begin
         st_reg <= st_next;
      end
   end

   // ----------------------------------------------------------------
   // read mux
   // ----------------------------------------------------------------
   always_comb begin
      unique case (sfr_addr)
         rtctk_pkg::CONFIG_ADDR:    sfr_rdata = st_reg.cfg;
         rtctk_pkg::FRAC_ADDR:      sfr_rdata = st_reg.frac;
         rtctk_pkg::SEC_ADDR:       sfr_rdata = st_reg.sec;
         rtctk_pkg::MIN_ADDR:       sfr_rdata = st_reg.min;
         rtctk_pkg::HOUR_ADDR:      sfr_rdata = st_reg.hour;
         rtctk_pkg::ALARM_INTERVAL_TARGET_ADDR:    sfr_rdata = st_reg.target;
         rtctk_pkg::KEY_ADDR:       sfr_rdata = st_reg.key;
         rtctk_pkg::NOMTRIM_ADDR:   sfr_rdata = st_reg.nom;
         rtctk_pkg::THERMTRIM_ADDR: sfr_rdata = st_reg.therm;
         default:                   sfr_rdata = 8'h00;
      endcase
   end

   assign rtc_irq_pend = st_reg.irq;
   assign nom_trim     = st_reg.nom;
   assign therm_trim   = st_reg.therm;
endmodule

// ==== dv/rtctk_core_chk.sv ====
// Purpose: port level assertions for rtctk_core
// Assumes: key state is rebuilt from sfr writes seen at the ports
// Notes:   bound to every rtctk_core instance
`timescale 1ns/1ps
module rtctk_core_chk #(
   parameter int XTAL_DIV = rtctk_pkg::XTAL_DIV
) (
   input wire logic       mclk,          // clock
   input wire logic       arst_n,        // power-on reset, low
   input wire logic       xtal_tick,     // crystal tick
   input wire logic [7:0] sfr_addr,      // sfr address
   input wire logic       sfr_wr,        // write strobe
   input wire logic [7:0] sfr_wdata,     // write data
   input wire logic [7:0] sfr_rdata,     // read data
   input wire logic       rtc_irq_pend,  // interrupt pulse
   input wire logic [7:0] nom_trim,      // nominal trim
   input wire logic [7:0] therm_trim     // thermal trim
);
   // ----------------------------------------------------------------
   // helper state
   // ----------------------------------------------------------------
   logic [7:0] key_reg;
   logic       wr_sec;
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!arst_n);
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) key_reg <= 8'h00;
      else if (sfr_wr && sfr_addr == rtctk_pkg::KEY_ADDR) key_reg <= sfr_wdata;
   end
   assign wr_sec = sfr_wr && sfr_addr == rtctk_pkg::SEC_ADDR;
   property p_step(a, last);
      sfr_addr == a && $past(sfr_addr) == a && !$past(sfr_wr) |->
         sfr_rdata == $past(sfr_rdata) || sfr_rdata == $past(sfr_rdata) + 8'h01 ||
         ($past(sfr_rdata) == last && sfr_rdata == 8'h00);
   endproperty
   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   a_frac_step: assert property (p_step(rtctk_pkg::FRAC_ADDR, rtctk_pkg::FRAC_LAST))
      else $error("frac counter jumped");
   a_sec_step: assert property (p_step(rtctk_pkg::SEC_ADDR, rtctk_pkg::SEC_LAST))
      else $error("seconds counter jumped");
   a_time_open: assert property (wr_sec && key_reg == rtctk_pkg::TIME_KEY ##1
      sfr_addr == rtctk_pkg::SEC_ADDR |-> sfr_rdata == $past(sfr_wdata))
      else $error("unlocked seconds write lost");
   a_time_shut: assert property (wr_sec && key_reg != rtctk_pkg::TIME_KEY &&
      sfr_wdata > rtctk_pkg::SEC_LAST ##1 sfr_addr == rtctk_pkg::SEC_ADDR
      |-> sfr_rdata != $past(sfr_wdata))
      else $error("locked seconds write taken");
   a_nom_follow: assert property (sfr_wr && sfr_addr == rtctk_pkg::NOMTRIM_ADDR
      |=> nom_trim == $past(sfr_wdata))
      else $error("nominal trim not loaded");
   a_therm_follow: assert property (sfr_wr && sfr_addr == rtctk_pkg::THERMTRIM_ADDR
      |=> therm_trim == $past(sfr_wdata))
      else $error("thermal trim not loaded");
   a_trim_hold: assert property (!(sfr_wr && (sfr_addr == rtctk_pkg::NOMTRIM_ADDR ||
      sfr_addr == rtctk_pkg::THERMTRIM_ADDR)) |=> $stable(nom_trim) && $stable(therm_trim))
      else $error("trim changed without write");
   a_unmapped_zero: assert property (!(sfr_addr inside {[8'hA1:8'hA6], 8'hC1, 8'hF6, 8'hF7})
      |-> sfr_rdata == 8'h00)
      else $error("unmapped read not zero");
   a_cfg_top_zero: assert property (sfr_addr == rtctk_pkg::CONFIG_ADDR |-> !sfr_rdata[7])
      else $error("config bit 7 set");
   c_irq: cover property (rtc_irq_pend);
   c_open: cover property (wr_sec && key_reg == rtctk_pkg::TIME_KEY);
   c_trim: cover property (sfr_wr && sfr_addr == rtctk_pkg::NOMTRIM_ADDR);
endmodule

bind rtctk_core rtctk_core_chk #(.XTAL_DIV(XTAL_DIV)) i_chk (.mclk, .arst_n, .xtal_tick,
   .sfr_addr, .sfr_wr, .sfr_wdata, .sfr_rdata, .rtc_irq_pend, .nom_trim, .therm_trim);

// ==== dv/rtctk_core_tb.sv ====
// Purpose: self-checking bench for rtctk_core
// Assumes: XTAL_DIV of 2 so the chain runs fast
// Notes:   crystal ticks every cycle while run is set
`timescale 1ns/1ps
module rtctk_core_tb;
   localparam int DIV = 2;
   logic       mclk, arst_n, xtal_tick, sfr_wr, rtc_irq_pend, run;
   logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, nom_trim, therm_trim, v, t;
   logic [7:0] tab [8];
   int         miscompares, n_tests, i, n;
   rtctk_core #(.XTAL_DIV(DIV)) i_dut (.mclk, .arst_n, .xtal_tick, .sfr_addr, .sfr_wr,
      .sfr_wdata, .sfr_rdata, .rtc_irq_pend, .nom_trim, .therm_trim);
   // ----------------------------------------------------------------
   // tasks
   // ----------------------------------------------------------------
   task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
      n_tests++;
      if (got !== exp) begin
         miscompares++;
         $display("Error %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      sfr_addr = a;
      sfr_wdata = d;
      sfr_wr = 1'b1;
      @(posedge mclk);
      #1;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      sfr_wr = 1'b0;
      sfr_addr = a;
      #1;
      cmp(sfr_rdata, exp);
      @(posedge mclk);
      #1;
   endtask
   // counts cycles until the interrupt pulse, bounded by lim
   task automatic wait_irq(input int lim, input logic e);
      sfr_wr = 1'b0;
      n = 0;
      while (rtc_irq_pend !== 1'b1 && n < lim) begin
         @(posedge mclk);
         #1;
         n++;
      end
      cmp({7'h00, rtc_irq_pend}, {7'h00, e});
   endtask
   task automatic end_of_test;
      if (miscompares == 0 && n_tests > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   // ----------------------------------------------------------------
   // clock, crystal, watchdog
   // ----------------------------------------------------------------
   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end
   always @(posedge mclk) xtal_tick <= #1 run;
   initial begin
      #200000;
      miscompares++;
      end_of_test();
   end
   // ----------------------------------------------------------------
   // tests
   // ----------------------------------------------------------------
   initial begin
      {arst_n, run, sfr_wr, xtal_tick, sfr_addr, sfr_wdata} = '0;
      miscompares = 0;
      n_tests = 0;
      tab = '{rtctk_pkg::FRAC_ADDR, rtctk_pkg::SEC_ADDR, rtctk_pkg::MIN_ADDR,
         rtctk_pkg::HOUR_ADDR, rtctk_pkg::ALARM_INTERVAL_TARGET_ADDR, rtctk_pkg::NOMTRIM_ADDR,
         rtctk_pkg::THERMTRIM_ADDR, 8'h55};
      void'($urandom(33011));
      repeat (5) @(posedge mclk);
      #1 arst_n = 1'b1;
      rd(rtctk_pkg::CONFIG_ADDR, rtctk_pkg::CONFIG_RESET);
      for (i = 0; i < 8; i++) rd(tab[i], 8'h00);
      v = 8'($urandom);
      t = 8'($urandom);
      wr(rtctk_pkg::NOMTRIM_ADDR, v);
      wr(rtctk_pkg::THERMTRIM_ADDR, t);
      rd(rtctk_pkg::NOMTRIM_ADDR, v);
      cmp(nom_trim, v);
      rd(rtctk_pkg::THERMTRIM_ADDR, t);
      cmp(therm_trim, t);
      wr(rtctk_pkg::SEC_ADDR, 8'h40 | v);
      rd(rtctk_pkg::SEC_ADDR, 8'h00);
      for (i = 0; i < 5; i++) begin
         v = 8'($urandom_range(0, 59));
         wr(rtctk_pkg::KEY_ADDR, rtctk_pkg::TIME_KEY);
         wr(tab[i], v);
         rd(tab[i], v);
      end
      for (i = 0; i < 2; i++) begin
         t = i ? 8'h01 : 8'h41;
         wr(rtctk_pkg::CONFIG_ADDR, t);
         wr(rtctk_pkg::KEY_ADDR, rtctk_pkg::TIME_KEY);
         wr(rtctk_pkg::HOUR_ADDR, i ? rtctk_pkg::HOUR256_LAST : rtctk_pkg::HOUR24_LAST);
         wr(rtctk_pkg::MIN_ADDR, rtctk_pkg::MIN_LAST);
         wr(rtctk_pkg::SEC_ADDR, rtctk_pkg::SEC_LAST);
         wr(rtctk_pkg::FRAC_ADDR, rtctk_pkg::FRAC_LAST);
         run = 1'b1;
         wait_irq(20, 1'b1);
         run = 1'b0;
         rd(rtctk_pkg::HOUR_ADDR, 8'h00);
         rd(rtctk_pkg::MIN_ADDR, 8'h00);
         rd(rtctk_pkg::SEC_ADDR, 8'h00);
         rd(rtctk_pkg::CONFIG_ADDR, t | 8'h20);
         wr(rtctk_pkg::CONFIG_ADDR, 8'h01);
      end
      rd(rtctk_pkg::CONFIG_ADDR, 8'h01);
      t = 8'($urandom_range(2, 6));
      wr(rtctk_pkg::ALARM_INTERVAL_TARGET_ADDR, t);
      wr(rtctk_pkg::CONFIG_ADDR, 8'h03);
      run = 1'b1;
      wait_irq(64, 1'b1);
      @(posedge mclk);
      #1;
      wait_irq(64, 1'b1);
      cmp(8'(n + 1), 8'(t * DIV));
      rd(rtctk_pkg::CONFIG_ADDR, 8'h07);
      wr(rtctk_pkg::CONFIG_ADDR, 8'h01);
      wr(rtctk_pkg::ALARM_INTERVAL_TARGET_ADDR, 8'h01);
      wr(rtctk_pkg::CONFIG_ADDR, 8'h0B);
      wait_irq(300, 1'b1);
      @(posedge mclk);
      #1;
      wait_irq(600, 1'b0);
      end_of_test();
   end
endmodule
